// >>> common/rstctl_pkg.sv
// Constants, register map and carrier types of the reset source controller
// Function
// - Nine sources combine into system reset
// - Config bit0 set disables external reset
// - Committed disable cleared by power-on only
// - Code b2 commits the written disable bit
// - Unlock decodes b2, d4, 71; others ignored
// - Config bits seven to three read zero
// - Address fdf reads mirror, writes unlock
// - Cause flags bits six to zero per source
// - Cause flags survive internal resets
// - Flag-clear bit plus code 71 clears flags
// - Flag-clear bit reads back as zero
// - Any reset holds counter, CPU, peripherals
// - Warm-up counts oscillator cycles after release
// - Warm-up loads trimming data into ladder
// - CPU then fetches vector at fffe
// - Reset during warm-up restarts the sequence
// - Every source gives the same CPU and peripheral reset
// - Power-on and external pin are ORed
// - Voltage detectors disabled by pin/power-on only
// - Oscillator off within 2 cycles: clock reset
package rstctl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CAUSE    = 16'h0fcc;
    localparam logic [15:0] ADDR_CONFIG   = 16'h0fde;
    localparam logic [15:0] ADDR_UNLOCK   = 16'h0fdf;
    localparam logic [7:0]  CAUSE_RESET   = 8'h00;
    localparam logic [2:0]  CONFIG_RESET  = 3'h0;
    localparam logic [7:0]  CODE_DISABLE  = 8'hb2;
    localparam logic [7:0]  CODE_PROTECT  = 8'hd4;
    localparam logic [7:0]  CODE_FLAGCLR  = 8'h71;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_DIS_BIT     = 0;
    localparam int FLAG_CLEAR_BIT  = 7;
    localparam int FLASH_BIT       = 6;
    localparam int TRIM_ABN_BIT    = 5;
    localparam int TRIM_BIT        = 4;
    localparam int VDET2_BIT       = 3;
    localparam int VDET1_BIT       = 2;
    localparam int CLKF_BIT        = 1;
    localparam int WDOG_BIT        = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [11:0] WARMUP_CYCLES = 12'h400;
    localparam logic [11:0] TRIM_LOAD_AT  = 12'h010;
    localparam logic [1:0]  CLK_GUARD_MC  = 2'h2;
    localparam logic [15:0] RESET_VECTOR  = 16'hfffe;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RESET, ST_WARMUP, ST_RUN} seq_state_t;

    // Raw asynchronous reset sources, active high
    typedef struct packed {
        logic flash_stby;
        logic trim_fault;
        logic vdet2;
        logic vdet1;
        logic watchdog;
        logic ext_pin;
    } rst_src_t;

endpackage

// >>> verilog/reset_source_controller.sv
// Reset source controller: source merge, warm-up sequencer and registers
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller
(
    // Clock and power-on reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // Asynchronous reset sources
    input  wire rstctl_pkg::rst_src_t  i_src,
    // Clock switch supervision
    input  wire logic                  i_mcycle_tick,
    input  wire logic                  i_main_clk_switch,
    input  wire logic                  i_osc_en_clear,
    // Trimming memory
    input  wire logic [7:0]            i_trim_data,
    input  wire logic                  i_trim_abnormal,
    // Register port
    input  wire logic [15:0]           i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [7:0]                 o_rdata,
    // Reset outputs
    output logic                       o_cpu_rst,
    output logic                       o_periph_rst,
    output logic                       o_warmup_active,
    output logic                       o_vdet_disable,
    output logic [15:0]                o_fetch_vector,
    output logic                       o_cpu_start,
    // Trimming outputs
    output logic                       o_trim_rd,
    output logic [7:0]                 o_trim_ladder,
    // Protected settings
    output logic                       o_ext_reset_disable,
    output logic [1:0]                 o_protect_cfg
);

    // ------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------
    rstctl_pkg::rst_src_t src_meta_q;
    rstctl_pkg::rst_src_t src_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            src_meta_q <= '0;
            src_q      <= '0;
        end
        else
        begin
            src_meta_q <= i_src;
            src_q      <= src_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Clock fault supervision
    // ------------------------------------------------------------
    // Counts machine cycles after a main clock switch; an oscillator
    // disable inside the guard window is a clock fault reset.
    logic [1:0] guard_cnt_q;
    logic       guard_open_q;
    logic       clk_fault_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            guard_cnt_q  <= 2'h0;
            guard_open_q <= 1'b0;
        end
        else if (i_main_clk_switch)
        begin
            guard_cnt_q  <= 2'h0;
            guard_open_q <= 1'b1;
        end
        else if (guard_open_q && i_mcycle_tick)
        begin
            guard_cnt_q  <= guard_cnt_q + 2'h1;
            if (guard_cnt_q + 2'h1 >= rstctl_pkg::CLK_GUARD_MC)
                guard_open_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            clk_fault_q <= 1'b0;
        else
            clk_fault_q <= guard_open_q && i_osc_en_clear;
    end

    // ------------------------------------------------------------
    // Reset merge
    // ------------------------------------------------------------
    rstctl_pkg::seq_state_t state_q;
    logic       ext_dis_commit_q;
    logic       trim_fault_q;
    logic       ext_eff;
    logic       internal_rst;
    logic       pin_or_por;
    logic       sys_rst;

    assign ext_eff      = src_q.ext_pin && !ext_dis_commit_q;
    assign pin_or_por   = i_rst || ext_eff;
    assign internal_rst = src_q.flash_stby || src_q.trim_fault ||
                          src_q.vdet2 || src_q.vdet1 ||
                          src_q.watchdog || clk_fault_q || trim_fault_q;
    assign sys_rst      = pin_or_por || internal_rst;

    // ------------------------------------------------------------
    // Warm-up sequencer
    // ------------------------------------------------------------
    logic [11:0] warm_cnt_q;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
        begin
            state_q    <= rstctl_pkg::ST_RESET;
            warm_cnt_q <= 12'h0;
        end
        else
        begin
            case (state_q)
                rstctl_pkg::ST_RESET:
                begin
                    state_q    <= rstctl_pkg::ST_WARMUP;
                    warm_cnt_q <= 12'h0;
                end
                rstctl_pkg::ST_WARMUP:
                begin
                    warm_cnt_q <= warm_cnt_q + 12'h1;
                    if (warm_cnt_q == rstctl_pkg::WARMUP_CYCLES - 12'h1)
                        state_q <= rstctl_pkg::ST_RUN;
                end
                rstctl_pkg::ST_RUN:
                    state_q <= rstctl_pkg::ST_RUN;
                default:
                    state_q <= rstctl_pkg::ST_RESET;
            endcase
        end
    end

    // CPU and peripherals stay held until warm-up ends
    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
        begin
            o_cpu_rst       <= 1'b1;
            o_periph_rst    <= 1'b1;
            o_warmup_active <= 1'b0;
            o_cpu_start     <= 1'b0;
        end
        else
        begin
            o_cpu_rst       <= (state_q != rstctl_pkg::ST_RUN);
            o_periph_rst    <= (state_q != rstctl_pkg::ST_RUN);
            o_warmup_active <= (state_q == rstctl_pkg::ST_WARMUP);
            o_cpu_start     <= (state_q == rstctl_pkg::ST_WARMUP) &&
                               (warm_cnt_q == rstctl_pkg::WARMUP_CYCLES - 12'h1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_fetch_vector <= rstctl_pkg::RESET_VECTOR;
        else
            o_fetch_vector <= rstctl_pkg::RESET_VECTOR;
    end

    // Only pin or power-on reset turns the voltage detectors off
    always_ff @(posedge i_clk)
    begin
        if (pin_or_por)
            o_vdet_disable <= 1'b1;
        else if (state_q == rstctl_pkg::ST_RUN)
            o_vdet_disable <= 1'b0;
    end

    // ------------------------------------------------------------
    // Trimming load
    // ------------------------------------------------------------
    // Memory answers one cycle after the read strobe.
    logic trim_pend_q;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
        begin
            o_trim_rd   <= 1'b0;
            trim_pend_q <= 1'b0;
        end
        else
        begin
            o_trim_rd   <= (state_q == rstctl_pkg::ST_WARMUP) &&
                           (warm_cnt_q == rstctl_pkg::TRIM_LOAD_AT);
            trim_pend_q <= o_trim_rd;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_trim_ladder <= 8'h00;
        else if (trim_pend_q)
            o_trim_ladder <= i_trim_data;
    end

    // Abnormal trimming seen at load forces a trimming reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            trim_fault_q <= 1'b0;
        else
            trim_fault_q <= trim_pend_q && i_trim_abnormal;
    end

    // ------------------------------------------------------------
    // Configuration and unlock
    // ------------------------------------------------------------
    logic [2:0] cfg_q;
    logic [1:0] prot_commit_q;
    logic       wr_cfg;
    logic       wr_unlock;
    logic       wr_cause;

    // Plain byte writes only; no read side effects exist to misuse
    assign wr_cfg    = i_wr && (i_addr == rstctl_pkg::ADDR_CONFIG);
    assign wr_unlock = i_wr && (i_addr == rstctl_pkg::ADDR_UNLOCK);
    assign wr_cause  = i_wr && (i_addr == rstctl_pkg::ADDR_CAUSE);

    // Written copy falls back on any reset
    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
            cfg_q <= rstctl_pkg::CONFIG_RESET;
        else if (wr_cfg)
            cfg_q <= i_wdata[2:0];
    end

    // Committed copies survive everything but power-on
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ext_dis_commit_q <= 1'b0;
        else if (wr_unlock && i_wdata == rstctl_pkg::CODE_DISABLE)
            ext_dis_commit_q <= cfg_q[rstctl_pkg::CFG_DIS_BIT];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            prot_commit_q <= 2'h0;
        else if (wr_unlock && i_wdata == rstctl_pkg::CODE_PROTECT)
            prot_commit_q <= cfg_q[2:1];
    end

    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    logic       flag_clear_request_q;
    logic [6:0] cause_q;
    logic [6:0] cause_set;
    logic       flag_clear;

    assign flag_clear = wr_unlock && (i_wdata == rstctl_pkg::CODE_FLAGCLR) && flag_clear_request_q;

    always_comb
    begin
        cause_set                         = 7'h00;
        cause_set[rstctl_pkg::FLASH_BIT]  = src_q.flash_stby;
        cause_set[rstctl_pkg::TRIM_ABN_BIT] = trim_fault_q;
        cause_set[rstctl_pkg::TRIM_BIT]   = src_q.trim_fault || trim_fault_q;
        cause_set[rstctl_pkg::VDET2_BIT]  = src_q.vdet2;
        cause_set[rstctl_pkg::VDET1_BIT]  = src_q.vdet1;
        cause_set[rstctl_pkg::CLKF_BIT]   = clk_fault_q;
        cause_set[rstctl_pkg::WDOG_BIT]   = src_q.watchdog;
    end

    // Set wins over the software clear; internal resets leave flags alone
    always_ff @(posedge i_clk)
    begin
        if (pin_or_por)
            cause_q <= rstctl_pkg::CAUSE_RESET[6:0];
        else if (flag_clear)
            cause_q <= cause_set;
        else
            cause_q <= cause_q | cause_set;
    end

    always_ff @(posedge i_clk)
    begin
        if (pin_or_por)
            flag_clear_request_q <= 1'b0;
        else if (flag_clear)
            flag_clear_request_q <= 1'b0;
        else if (wr_cause)
            flag_clear_request_q <= i_wdata[rstctl_pkg::FLAG_CLEAR_BIT];
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !i_rd)
            o_rdata <= 8'h00;
        else
        begin
            case (i_addr)
                rstctl_pkg::ADDR_CAUSE:  o_rdata <= {1'b0, cause_q};
                rstctl_pkg::ADDR_CONFIG: o_rdata <= {5'h00, cfg_q};
                rstctl_pkg::ADDR_UNLOCK: o_rdata <= {5'h00, prot_commit_q,
                                                     ext_dis_commit_q};
                default:                 o_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_ext_reset_disable <= 1'b0;
            o_protect_cfg       <= 2'h0;
        end
        else
        begin
            o_ext_reset_disable <= ext_dis_commit_q;
            o_protect_cfg       <= prot_commit_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    hold_in_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        sys_rst |=> o_cpu_rst && o_periph_rst)
        else $error("CPU not held in reset");
    warmup_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_cpu_start) |-> $past(warm_cnt_q) == rstctl_pkg::WARMUP_CYCLES - 12'h1)
        else $error("Warm-up length wrong");
    restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == rstctl_pkg::ST_WARMUP && sys_rst) |=>
        state_q == rstctl_pkg::ST_RESET && warm_cnt_q == 12'h0)
        else $error("Warm-up not restarted");
    commit_b2_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_unlock && i_wdata == rstctl_pkg::CODE_DISABLE) |=>
        ext_dis_commit_q == $past(cfg_q[0]))
        else $error("Disable not committed");
    no_commit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_unlock && i_wdata == rstctl_pkg::CODE_DISABLE) |=> $stable(ext_dis_commit_q))
        else $error("Disable changed without code");
    // Pin asserted while masked and nothing else pending: CPU keeps running
    ext_masked_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (ext_dis_commit_q && src_q.ext_pin && !internal_rst &&
         state_q == rstctl_pkg::ST_RUN) |=> !o_cpu_rst)
        else $error("Disabled pin still resets");
    cause_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (src_q.watchdog && !pin_or_por) |=> cause_q[rstctl_pkg::WDOG_BIT])
        else $error("Watchdog cause not set");
    keep_flags_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (cause_q[0] && !pin_or_por && !flag_clear) |=> cause_q[0])
        else $error("Cause flag lost");
    flag_clear_request_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == rstctl_pkg::ADDR_CAUSE) |=> !o_rdata[7])
        else $error("Flag-clear bit read as one");
    cfg_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == rstctl_pkg::ADDR_CONFIG) |=> o_rdata[7:3] == 5'h00)
        else $error("Config upper bits not zero");
    clk_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_main_clk_switch ##1 (i_osc_en_clear && !i_main_clk_switch)) |=> clk_fault_q)
        else $error("Clock fault not raised");

    warm_done_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_cpu_start));
    restart_c:   cover property (@(posedge i_clk) disable iff (i_rst)
        state_q == rstctl_pkg::ST_WARMUP && sys_rst);
    flagclr_c:   cover property (@(posedge i_clk) disable iff (i_rst) flag_clear);

endmodule
`default_nettype wire

// >>> tb/reset_sources_model.sv
// Partner model: on-chip reset sources and trimming memory
`timescale 1ns/1ps
`default_nettype none
module reset_sources_model
#(
    parameter logic [7:0] TRIM_WORD = 8'h5a
)
(
    // Bench requests
    input  wire logic                 i_clk,
    input  wire rstctl_pkg::rst_src_t i_req,
    input  wire logic                 i_abn,
    // Device side
    input  wire logic                 i_trim_rd,
    output rstctl_pkg::rst_src_t      o_src,
    output logic [7:0]                o_trim_data,
    output logic                      o_trim_abnormal
);
    logic valid_q;
    logic armed_q;

    // Sources are levels that change just after an edge
    always @(posedge i_clk)
    begin
        o_src <= i_req;
        valid_q <= i_trim_rd;
        armed_q <= !i_abn ? 1'b1 : (i_trim_rd ? 1'b0 : armed_q);
        o_trim_abnormal <= i_trim_rd & i_abn & armed_q;
    end

    // Word valid only the cycle after the read; inverse otherwise
    assign o_trim_data = valid_q ? TRIM_WORD : ~TRIM_WORD;
endmodule
`default_nettype wire

// >>> tb/reset_source_controller_bench.sv
// Self-checking bench of the reset source controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module reset_source_controller_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 i_clk, i_rst, i_mcycle_tick, i_main_clk_switch;
    logic                 i_osc_en_clear, i_wr, i_rd, abn, i_trim_abnormal;
    logic                 o_cpu_rst, o_periph_rst, o_warmup_active, o_vdet_disable;
    logic                 o_cpu_start, o_trim_rd, o_ext_reset_disable;
    logic [15:0]          i_addr;
    logic [15:0]          o_fetch_vector;
    logic [7:0]           i_wdata, o_rdata, i_trim_data, o_trim_ladder, cause_exp;
    logic [1:0]           o_protect_cfg;
    rstctl_pkg::rst_src_t req, i_src;
    int                   err_count, cmp_count, starts, n;
    logic [5:0]           src_tab [5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic [7:0]           bit_tab [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h40};

    reset_source_controller i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_src(i_src),
        .i_mcycle_tick(i_mcycle_tick), .i_main_clk_switch(i_main_clk_switch),
        .i_osc_en_clear(i_osc_en_clear), .i_trim_data(i_trim_data),
        .i_trim_abnormal(i_trim_abnormal), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_rst(o_cpu_rst),
        .o_periph_rst(o_periph_rst), .o_warmup_active(o_warmup_active),
        .o_vdet_disable(o_vdet_disable), .o_fetch_vector(o_fetch_vector),
        .o_cpu_start(o_cpu_start), .o_trim_rd(o_trim_rd), .o_trim_ladder(o_trim_ladder),
        .o_ext_reset_disable(o_ext_reset_disable), .o_protect_cfg(o_protect_cfg));

    reset_sources_model i_model (.i_clk(i_clk), .i_req(req), .i_abn(abn),
        .i_trim_rd(o_trim_rd), .o_src(i_src), .o_trim_data(i_trim_data),
        .o_trim_abnormal(i_trim_abnormal));

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // Machine cycle tick every fourth clock
    initial
    begin
        i_mcycle_tick = 1'b0;
        forever
        begin
            repeat (3) @(posedge i_clk);
            i_mcycle_tick <= 1'b1;
            @(posedge i_clk);
            i_mcycle_tick <= 1'b0;
        end
    end

    always @(posedge i_clk)
        if (o_cpu_start === 1'b1)
            starts++;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask

    // Bounded wait for the CPU to leave reset, then judge the warm-up
    task automatic wait_run(input int lo, input int hi);
        int s0;
        s0 = starts;
        n = 0;
        while (o_cpu_rst !== 1'b0 && n < 4000)
        begin
            @(posedge i_clk);
            #1 n++;
            if (n == 512) `CHK(o_warmup_active, 1'b1)
        end
        repeat (2) @(posedge i_clk);
        `CHK(o_warmup_active, 1'b0)
        `CHK(n >= lo && n <= hi, 1'b1)
        `CHK(starts - s0, 1)
        `CHK(o_fetch_vector, rstctl_pkg::RESET_VECTOR)
    endtask

    task automatic run_reset(input logic [5:0] s, input logic vd, input int lo, hi);
        @(posedge i_clk);
        req <= rstctl_pkg::rst_src_t'(s);
        repeat (7) @(posedge i_clk);
        #1 `CHK(o_cpu_rst, 1'b1)
        `CHK(o_periph_rst, 1'b1)
        `CHK(o_vdet_disable, vd)
        @(posedge i_clk);
        req <= '0;
        wait_run(lo, hi);
    endtask

    // Gap counts clocks between the source switch and the oscillator clear
    task automatic clk_switch(input int gap);
        @(posedge i_clk);
        i_main_clk_switch <= 1'b1;
        @(posedge i_clk);
        i_main_clk_switch <= 1'b0;
        repeat (gap) @(posedge i_clk);
        i_osc_en_clear <= 1'b1;
        @(posedge i_clk);
        i_osc_en_clear <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_protect;
        wr(16'h0fcd, 8'hff);
        rd(16'h0fcd, 8'h00);
        wr(rstctl_pkg::ADDR_CONFIG, 8'hff);
        rd(rstctl_pkg::ADDR_CONFIG, 8'h07);
        rd(rstctl_pkg::ADDR_UNLOCK, 8'h00);
        wr(rstctl_pkg::ADDR_UNLOCK, 8'h55);
        rd(rstctl_pkg::ADDR_UNLOCK, 8'h00);
        wr(rstctl_pkg::ADDR_UNLOCK, rstctl_pkg::CODE_DISABLE);
        rd(rstctl_pkg::ADDR_UNLOCK, 8'h01);
        wr(rstctl_pkg::ADDR_UNLOCK, rstctl_pkg::CODE_PROTECT);
        rd(rstctl_pkg::ADDR_UNLOCK, 8'h07);
        `CHK(o_protect_cfg, 2'h3)
        req <= rstctl_pkg::rst_src_t'(6'h01);
        repeat (12) @(posedge i_clk);
        #1 `CHK(o_cpu_rst, 1'b0)
        req <= '0;
        $display("test protect done");
    endtask

    task automatic t_sources;
        for (int k = 0; k < 5; k++)
        begin
            run_reset(src_tab[k], 1'b0, 1024, 1040);
            cause_exp = cause_exp | bit_tab[k];
            rd(rstctl_pkg::ADDR_CAUSE, cause_exp);
            rd(rstctl_pkg::ADDR_CONFIG, 8'h00);
            `CHK(o_ext_reset_disable, 1'b1)
        end
        clk_switch(24);
        `CHK(o_cpu_rst, 1'b0)
        clk_switch(0);
        `CHK(o_cpu_rst, 1'b1)
        wait_run(1000, 1040);
        cause_exp = cause_exp | 8'h02;
        rd(rstctl_pkg::ADDR_CAUSE, cause_exp);
        abn <= 1'b1;
        run_reset(6'h02, 1'b0, 1050, 1200);
        abn <= 1'b0;
        cause_exp = cause_exp | 8'h30;
        rd(rstctl_pkg::ADDR_CAUSE, cause_exp);
        $display("test sources done");
    endtask

    task automatic t_flags;
        wr(rstctl_pkg::ADDR_UNLOCK, rstctl_pkg::CODE_FLAGCLR);
        rd(rstctl_pkg::ADDR_CAUSE, cause_exp);
        wr(rstctl_pkg::ADDR_CAUSE, 8'h80);
        rd(rstctl_pkg::ADDR_CAUSE, cause_exp);
        wr(rstctl_pkg::ADDR_UNLOCK, rstctl_pkg::CODE_FLAGCLR);
        rd(rstctl_pkg::ADDR_CAUSE, 8'h00);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 `CHK(o_vdet_disable, 1'b1)
        i_rst <= 1'b0;
        wait_run(1024, 1040);
        `CHK(o_ext_reset_disable, 1'b0)
        `CHK(o_protect_cfg, 2'h0)
        run_reset(6'h02, 1'b0, 1024, 1040);
        wr(rstctl_pkg::ADDR_UNLOCK, rstctl_pkg::CODE_FLAGCLR);
        rd(rstctl_pkg::ADDR_CAUSE, 8'h01);
        run_reset(6'h01, 1'b1, 1024, 1040);
        rd(rstctl_pkg::ADDR_CAUSE, 8'h00);
        $display("test flags done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {i_rst, i_wr, i_rd, abn} = 4'h8;
        {i_main_clk_switch, i_osc_en_clear} = 2'h0;
        {i_addr, i_wdata, req, cause_exp} = '0;
        {err_count, cmp_count} = '0;
        repeat (16) @(posedge i_clk);
        #1 `CHK(o_cpu_rst, 1'b1)
        `CHK(o_vdet_disable, 1'b1)
        i_rst <= 1'b0;
        wait_run(1024, 1040);
        `CHK(o_vdet_disable, 1'b0)
        `CHK(o_trim_ladder, 8'h5a)
        rd(rstctl_pkg::ADDR_CAUSE, 8'h00);
        $display("test boot done");
        t_protect;
        t_sources;
        t_flags;
        results;
    end

    // Hang guard: about three times the expected run
    initial
    begin
        repeat (40000) @(posedge i_clk);
        err_count++;
        results;
    end
endmodule
`default_nettype wire
